/* hdl/ccl_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * clock controller. Assumes a 200 MHz controller clock.
 */
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH

`define CCL_CLK_MHZ 200
`define CCL_STAB_TIME_NS 1000
`define CCL_STAB_CYC ((`CCL_STAB_TIME_NS * `CCL_CLK_MHZ + 999) / 1000)
`define CCL_FAIL_TIME_NS 2000
`define CCL_FAIL_CYC ((`CCL_FAIL_TIME_NS * `CCL_CLK_MHZ + 999) / 1000)

`define CCL_OFS_SWITCH 12'h000
`define CCL_OFS_STATUS 12'h004
`define CCL_OFS_GATE 12'h008
`define CCL_OFS_PWR 12'h00C
`define CCL_OFS_TRIM 12'h010
`define CCL_OFS_WAKE 12'h014

`define CCL_SW_SRC 1:0
`define CCL_SW_DIV 3:2
`define CCL_PWR_MODE 1:0
`define CCL_PWR_REGOFF 2
`define CCL_PWR_MON_EN 3
`define CCL_PWR_WAKE_EXT 4
`define CCL_PWR_PLL_EXT 5
`define CCL_PWR_CO_SEL 7:6
`define CCL_PWR_CO_EN 8
`define CCL_ST_FAIL 5

`define CCL_DIV_RST 2'h3
`define CCL_PWR_RST 9'h000
`define CCL_TRIM_RST 3'h4
`define CCL_WAKE_RST 16'h0100

`endif

/* hdl/ccl_pkg.sv */
/*
 * Types of the clock controller: sources, modes, states, bus carriers.
 * Assumes an APB master with 12 address bits and 32-bit data.
 */
package ccl_pkg;

typedef enum logic [1:0] {
    CCL_SRC_FAST = 2'h0,
    CCL_SRC_SLOW = 2'h1,
    CCL_SRC_EXT = 2'h2
} ccl_src_e;

typedef enum logic [1:0] {
    CCL_MODE_RUN = 2'h0,
    CCL_MODE_WAIT = 2'h1,
    CCL_MODE_AHALT = 2'h2,
    CCL_MODE_HALT = 2'h3
} ccl_mode_e;

typedef enum logic [4:0] {
    CCL_ST_RUN = 5'h01,
    CCL_ST_WAIT_RDY = 5'h02,
    CCL_ST_GAP = 5'h04,
    CCL_ST_LOWPWR = 5'h08,
    CCL_ST_STAB = 5'h10
} ccl_state_e;

typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
} ccl_apb_req_s;

typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} ccl_apb_rsp_s;

endpackage

/* hdl/ccl_top.sv */
/*
 * Master clock source selection, divider, gating and low-power sequencing,
 * with failure monitor and APB registers.
 * Assumes oscillator ready flags and clock/event pins are asynchronous,
 * INT_REQ_IN comes from logic on CLK_IN.
 */
// How it works
// - reset runs master clock from fast /8
// - switch waits for ready, break before make
// - core and each peripheral clock gateable
// - wakeup on fast /8, then restore selection
// - monitored external failure forces fast /8
// - PLL output never a master selection
// - PLL reference is fast or external only
// - slow osc drives wake unit, master-selectable
// - fast osc default with 3-bit trim
// - wake time base slow or external tick
// - wait stops core and clears master select, peripherals keep gating, interrupt wakes
// - active-halt stops all, periodic or event wake
// - active-halt regulator on or off variants
// - halt stops clocks, regulator off, event wakes
// - selected clock routed to output pin
// - master clock only from three oscillators
`timescale 1ns/100ps
`include "ccl_cfg.svh"

module ccl_top import ccl_pkg::*; #(
    parameter int PERIPH_N = 8
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire ccl_apb_req_s APB_IN,
    output ccl_apb_rsp_s APB_OUT,
    input wire logic [2:0] OSC_RDY_IN,
    input wire logic EXT_OSC_CLK_IN,
    input wire logic SLOW_OSC_CLK_IN,
    input wire logic EXT_TICK_128K_IN,
    input wire logic EXT_EVENT_IN,
    input wire logic INT_REQ_IN,
    output logic [2:0] MCLK_SEL_OUT,
    output logic [1:0] MCLK_DIV_OUT,
    output logic CPU_CLK_EN_OUT,
    output logic [PERIPH_N-1:0] PERIPH_CLK_EN_OUT,
    output logic MAIN_REG_ON_OUT,
    output logic PLL_REF_EXT_OUT,
    output logic [2:0] FAST_TRIM_OUT,
    output logic WAKE_TBASE_EXT_OUT,
    output logic [1:0] CLKOUT_SEL_OUT,
    output logic CLKOUT_EN_OUT
);

function automatic logic src_legal(input logic [1:0] code);
    src_legal = (code != 2'h3);
endfunction

function automatic logic [2:0] src_onehot(input ccl_src_e src);
    src_onehot = 3'h1 << src;
endfunction

// pin synchronisers and edge detect
logic [6:0] meta_reg;
logic [6:0] sync_reg;
logic [6:0] last_reg;
wire [6:0] pin_raw = {EXT_EVENT_IN, EXT_TICK_128K_IN, SLOW_OSC_CLK_IN, EXT_OSC_CLK_IN,
                      OSC_RDY_IN};
wire [6:0] rise = sync_reg & ~last_reg;
wire [2:0] rdy = sync_reg[2:0];
wire ext_edge = rise[3];
wire slow_edge = rise[4];
wire tick_edge = rise[5];
wire evt = rise[6];

always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
        meta_reg <= 7'h00;
        sync_reg <= 7'h00;
        last_reg <= 7'h00;
    end else if (CE_IN) begin
        meta_reg <= pin_raw;
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
    end
end

// register state
ccl_apb_rsp_s rsp_reg;
ccl_src_e src_req_reg;
logic [1:0] div_req_reg;
logic [8:0] pwr_reg;
logic [PERIPH_N-1:0] gate_reg;
logic [2:0] trim_reg;
logic [15:0] ivl_reg;
logic fail_flag_reg;

ccl_state_e state_reg, state_next;
ccl_src_e act_src_reg, act_src_next, tgt_src_reg, tgt_src_next;
logic [1:0] act_div_reg, act_div_next, tgt_div_reg, tgt_div_next;
ccl_mode_e lp_mode_reg, lp_mode_next;
logic resume_reg, resume_next;
logic [15:0] awu_cnt_reg;
logic [9:0] stab_cnt_reg;
logic [9:0] miss_cnt_reg;
logic [2:0] mclk_sel_reg;
logic [1:0] mclk_div_reg;
logic cpu_en_reg;
logic [PERIPH_N-1:0] periph_en_reg;
logic reg_on_reg;

// apb decode, one wait state
wire acc_req = APB_IN.psel & APB_IN.penable;
wire first_acc = acc_req & ~rsp_reg.pready;
wire wr_commit = acc_req & APB_IN.pwrite & rsp_reg.pready;
wire [31:0] wd = APB_IN.pwdata;
wire hit_switch = APB_IN.paddr == `CCL_OFS_SWITCH;
wire hit_status = APB_IN.paddr == `CCL_OFS_STATUS;
wire hit_gate = APB_IN.paddr == `CCL_OFS_GATE;
wire hit_pwr = APB_IN.paddr == `CCL_OFS_PWR;
wire hit_trim = APB_IN.paddr == `CCL_OFS_TRIM;
wire hit_wake = APB_IN.paddr == `CCL_OFS_WAKE;
wire map_hit = hit_switch | hit_status | hit_gate | hit_pwr | hit_trim | hit_wake;
wire busy = state_reg != CCL_ST_RUN;
wire [31:0] status_word = {21'h00_0000, lp_mode_reg, rdy, fail_flag_reg, busy,
                           act_div_reg, act_src_reg};
wire [31:0] rd_mux = hit_switch ? {28'h000_0000, div_req_reg, src_req_reg} :
                     hit_status ? status_word :
                     hit_gate ? 32'(gate_reg) :
                     hit_pwr ? {23'h00_0000, pwr_reg} :
                     hit_trim ? {29'h0000_0000, trim_reg} :
                     hit_wake ? {16'h0000, ivl_reg} : 32'h0000_0000;
wire lp_req = wr_commit & hit_pwr & (wd[`CCL_PWR_MODE] != 2'h0);

// monitor, wake and stabilisation helpers
wire mon_active = pwr_reg[`CCL_PWR_MON_EN] & (act_src_reg == CCL_SRC_EXT) &
                  (state_reg != CCL_ST_LOWPWR);
wire fail_evt = mon_active & ~ext_edge & (miss_cnt_reg == 10'(`CCL_FAIL_CYC - 1));
wire tb_edge = pwr_reg[`CCL_PWR_WAKE_EXT] ? tick_edge : slow_edge;
wire awu_run = (state_reg == CCL_ST_LOWPWR) & (lp_mode_reg == CCL_MODE_AHALT);
wire awu_wake = awu_run & (awu_cnt_reg == ivl_reg);
wire stab_done = stab_cnt_reg == 10'(`CCL_STAB_CYC - 1);
wire need_switch = (src_req_reg != act_src_reg) | (div_req_reg != act_div_reg);
wire tgt_rdy = rdy[tgt_src_reg];
logic wake;

always_comb begin
    unique case (lp_mode_reg)
        CCL_MODE_WAIT: wake = INT_REQ_IN | evt;
        CCL_MODE_AHALT: wake = awu_wake | evt;
        CCL_MODE_HALT: wake = evt;
        CCL_MODE_RUN: wake = 1'b0;
    endcase
end

always_comb begin
    state_next = state_reg;
    act_src_next = act_src_reg;
    act_div_next = act_div_reg;
    tgt_src_next = tgt_src_reg;
    tgt_div_next = tgt_div_reg;
    lp_mode_next = lp_mode_reg;
    resume_next = resume_reg;
    if (fail_evt) begin
        tgt_src_next = CCL_SRC_FAST;
        tgt_div_next = `CCL_DIV_RST;
        resume_next = 1'b0;
        state_next = CCL_ST_GAP;
    end else begin
        unique case (state_reg)
            CCL_ST_RUN: begin
                if (lp_req) begin
                    lp_mode_next = ccl_mode_e'(wd[`CCL_PWR_MODE]);
                    state_next = CCL_ST_LOWPWR;
                end else if (need_switch) begin
                    tgt_src_next = src_req_reg;
                    tgt_div_next = div_req_reg;
                    state_next = CCL_ST_WAIT_RDY;
                end
            end
            CCL_ST_WAIT_RDY: begin
                if (tgt_rdy) begin
                    state_next = CCL_ST_GAP;
                end
            end
            CCL_ST_GAP: begin
                act_src_next = tgt_src_reg;
                act_div_next = tgt_div_reg;
                resume_next = 1'b0;
                state_next = resume_reg ? CCL_ST_STAB : CCL_ST_RUN;
            end
            CCL_ST_LOWPWR: begin
                if (wake) begin
                    tgt_src_next = CCL_SRC_FAST;
                    tgt_div_next = `CCL_DIV_RST;
                    resume_next = 1'b1;
                    lp_mode_next = CCL_MODE_RUN;
                    state_next = CCL_ST_GAP;
                end
            end
            CCL_ST_STAB: begin
                if (stab_done) begin
                    state_next = CCL_ST_RUN;
                end
            end
            default: state_next = CCL_ST_RUN;
        endcase
    end
end

wire lp_next = state_next == CCL_ST_LOWPWR;
wire stop_periph = lp_next & (lp_mode_next != CCL_MODE_WAIT);
wire reg_off = lp_next & ((lp_mode_next == CCL_MODE_HALT) |
               ((lp_mode_next == CCL_MODE_AHALT) & pwr_reg[`CCL_PWR_REGOFF]));

always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
        state_reg <= CCL_ST_RUN;
        act_src_reg <= CCL_SRC_FAST;
        act_div_reg <= `CCL_DIV_RST;
        tgt_src_reg <= CCL_SRC_FAST;
        tgt_div_reg <= `CCL_DIV_RST;
        lp_mode_reg <= CCL_MODE_RUN;
        resume_reg <= 1'b0;
        mclk_sel_reg <= 3'h1;
        mclk_div_reg <= `CCL_DIV_RST;
        cpu_en_reg <= 1'b1;
        periph_en_reg <= '1;
        reg_on_reg <= 1'b1;
    end else if (CE_IN) begin
        state_reg <= state_next;
        act_src_reg <= act_src_next;
        act_div_reg <= act_div_next;
        tgt_src_reg <= tgt_src_next;
        tgt_div_reg <= tgt_div_next;
        lp_mode_reg <= lp_mode_next;
        resume_reg <= resume_next;
        mclk_sel_reg <= lp_next | (state_next == CCL_ST_GAP) ? 3'h0 :
                        src_onehot(act_src_next);
        mclk_div_reg <= act_div_next;
        cpu_en_reg <= ~lp_next;
        periph_en_reg <= stop_periph ? '0 : gate_reg;
        reg_on_reg <= ~reg_off;
    end
end

always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
        awu_cnt_reg <= 16'h0000;
        stab_cnt_reg <= 10'h000;
        miss_cnt_reg <= 10'h000;
    end else if (CE_IN) begin
        awu_cnt_reg <= ~awu_run ? 16'h0000 : awu_cnt_reg + 16'(tb_edge);
        stab_cnt_reg <= (state_reg == CCL_ST_STAB) ? stab_cnt_reg + 10'h001 : 10'h000;
        if (~mon_active | ext_edge) begin
            miss_cnt_reg <= 10'h000;
        end else if (miss_cnt_reg != 10'(`CCL_FAIL_CYC)) begin
            miss_cnt_reg <= miss_cnt_reg + 10'h001;
        end
    end
end

// software registers; failure overrides the request so it is not undone
always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
        rsp_reg <= '0;
        src_req_reg <= CCL_SRC_FAST;
        div_req_reg <= `CCL_DIV_RST;
        pwr_reg <= `CCL_PWR_RST;
        gate_reg <= '1;
        trim_reg <= `CCL_TRIM_RST;
        ivl_reg <= `CCL_WAKE_RST;
        fail_flag_reg <= 1'b0;
    end else if (CE_IN) begin
        rsp_reg.pready <= first_acc;
        rsp_reg.pslverr <= first_acc & ~map_hit;
        rsp_reg.prdata <= (first_acc & ~APB_IN.pwrite) ? rd_mux : 32'h0000_0000;
        if (fail_evt) begin
            src_req_reg <= CCL_SRC_FAST;
            div_req_reg <= `CCL_DIV_RST;
        end else if (wr_commit & hit_switch) begin
            if (src_legal(wd[`CCL_SW_SRC])) begin
                src_req_reg <= ccl_src_e'(wd[`CCL_SW_SRC]);
            end
            div_req_reg <= wd[`CCL_SW_DIV];
        end
        if (wr_commit & hit_pwr) begin
            pwr_reg <= {wd[8:2], 2'h0};
        end
        if (wr_commit & hit_gate) begin
            gate_reg <= wd[PERIPH_N-1:0];
        end
        if (wr_commit & hit_trim) begin
            trim_reg <= wd[2:0];
        end
        if (wr_commit & hit_wake) begin
            ivl_reg <= wd[15:0];
        end
        if (fail_evt) begin
            fail_flag_reg <= 1'b1;
        end else if (wr_commit & hit_status & wd[`CCL_ST_FAIL]) begin
            fail_flag_reg <= 1'b0;
        end
    end
end

assign APB_OUT = rsp_reg;
assign MCLK_SEL_OUT = mclk_sel_reg;
assign MCLK_DIV_OUT = mclk_div_reg;
assign CPU_CLK_EN_OUT = cpu_en_reg;
assign PERIPH_CLK_EN_OUT = periph_en_reg;
assign MAIN_REG_ON_OUT = reg_on_reg;
assign PLL_REF_EXT_OUT = pwr_reg[`CCL_PWR_PLL_EXT];
assign FAST_TRIM_OUT = trim_reg;
assign WAKE_TBASE_EXT_OUT = pwr_reg[`CCL_PWR_WAKE_EXT];
assign CLKOUT_SEL_OUT = pwr_reg[`CCL_PWR_CO_SEL];
assign CLKOUT_EN_OUT = pwr_reg[`CCL_PWR_CO_EN];

default clocking cb @(posedge CLK_IN); endclocking
default disable iff (RST_IN || !CE_IN);

property p_reset_fast;
    $fell(RST_IN) |-> act_src_reg == CCL_SRC_FAST && act_div_reg == 2'h3 && mclk_sel_reg == 3'h1;
endproperty
a_reset_fast: assert property (p_reset_fast) else $error("not fast /8 after reset");

property p_no_overlap;
    $changed(mclk_sel_reg) && mclk_sel_reg != 3'h0 |-> $past(mclk_sel_reg) == 3'h0;
endproperty
a_no_overlap: assert property (p_no_overlap) else $error("clock select overlap");

property p_hold_old;
    state_reg == CCL_ST_WAIT_RDY && !tgt_rdy && !fail_evt |=> state_reg == CCL_ST_WAIT_RDY;
endproperty
a_hold_old: assert property (p_hold_old) else $error("switched before ready");

property p_wait_core;
    state_reg == CCL_ST_LOWPWR && lp_mode_reg == CCL_MODE_WAIT |-> !cpu_en_reg && periph_en_reg == gate_reg;
endproperty
a_wait_core: assert property (p_wait_core) else $error("wait gating wrong");

property p_ahalt_stop;
    state_reg == CCL_ST_LOWPWR && lp_mode_reg != CCL_MODE_WAIT |-> periph_en_reg == '0 && !cpu_en_reg;
endproperty
a_ahalt_stop: assert property (p_ahalt_stop) else $error("peripherals not stopped");

property p_halt_evt;
    state_reg == CCL_ST_LOWPWR && lp_mode_reg == CCL_MODE_HALT && !evt |=> state_reg == CCL_ST_LOWPWR && !reg_on_reg;
endproperty
a_halt_evt: assert property (p_halt_evt) else $error("halt left without event");

property p_fail_fast;
    fail_evt |-> ##2 act_src_reg == CCL_SRC_FAST && act_div_reg == 2'h3 && mclk_sel_reg == 3'h1;
endproperty
a_fail_fast: assert property (p_fail_fast) else $error("no fallback after failure");

property p_wake_seq;
    state_reg == CCL_ST_LOWPWR && wake |-> ##2 state_reg == CCL_ST_STAB && act_src_reg == CCL_SRC_FAST;
endproperty
a_wake_seq: assert property (p_wake_seq) else $error("wake not on fast /8");

property p_three_src;
    src_legal(act_src_reg) && src_legal(src_req_reg);
endproperty
a_three_src: assert property (p_three_src) else $error("illegal master source");

property p_fail_flag;
    fail_evt |=> fail_flag_reg [*2];
endproperty
a_fail_flag: assert property (p_fail_flag) else $error("failure flag not held");

property p_status_late;
    $changed(act_src_reg) |-> $past(state_reg) == CCL_ST_GAP;
endproperty
a_status_late: assert property (p_status_late) else $error("status changed early");

endmodule

/* bench/ccl_osc_model.sv */
/*
 * Oscillator sources around the clock controller: fast and slow internal RC
 * ready flags, external crystal with start-up delay, wake-unit tick clocks.
 * Assumes the bench switches the external source on and off via ext_on_in.
 */
`timescale 1ns/100ps

module ccl_osc_model (
    input wire logic ext_on_in,
    output logic [2:0] osc_rdy_out,
    output logic ext_clk_out,
    output logic slow_clk_out,
    output logic tick_128k_out
);
    logic int_rdy;
    logic ext_rdy;

    initial begin
        int_rdy = 1'b0;
        ext_rdy = 1'b0;
        ext_clk_out = 1'b0;
        slow_clk_out = 1'b0;
        tick_128k_out = 1'b0;
        #10;
        int_rdy = 1'b1;
    end

    assign osc_rdy_out = {ext_rdy, int_rdy, int_rdy};

    // crystal start-up before ready, ready lost at once when it stops
    always @(posedge ext_on_in) #1000 ext_rdy = ext_on_in;
    always @(negedge ext_on_in) ext_rdy = 1'b0;

    // just under 16 MHz so it stays legal as master clock; stops dead when off
    always #31.3 ext_clk_out = ext_on_in ? ~ext_clk_out : ext_clk_out;
    always #3255.2 slow_clk_out = ~slow_clk_out;
    always #3906.3 tick_128k_out = ~tick_128k_out;
endmodule

/* bench/tb_clock_source_and_low_power_ctrl.sv */
/*
 * Self-checking bench of the clock controller over APB.
 * Assumes ccl_top with PERIPH_N 8 and the oscillator model beside it.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end

module tb_clock_source_and_low_power_ctrl import ccl_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ccl_apb_req_s req = '0;
    ccl_apb_rsp_s rsp;
    logic int_req = 1'b0;
    logic ext_event = 1'b0;
    logic ext_on = 1'b0;
    logic ce = 1'b1;
    logic [2:0] osc_rdy;
    logic ext_clk, slow_clk, tick;
    logic [2:0] sel, trim;
    logic [1:0] div, co_sel;
    logic [7:0] periph;
    logic cpu, main_reg, pll_ext, tbase, co_en, err;
    logic [31:0] rd;
    logic [31:0] rst_val [7] = '{32'h0000_000C, 32'h0000_00CC, 32'h0000_00FF,
        32'h0000_0000, 32'h0000_0004, 32'h0000_0100, 32'h0000_0000};
    logic [31:0] pw [3] = '{32'h0000_0006, 32'h0000_0002, 32'h0000_0003};
    int num_errors = 0;
    int compares = 0;
    int n;

    ccl_osc_model i_osc (.ext_on_in(ext_on), .osc_rdy_out(osc_rdy), .ext_clk_out(ext_clk),
        .slow_clk_out(slow_clk), .tick_128k_out(tick));

    ccl_top #(.PERIPH_N(8)) i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .APB_IN(req), .APB_OUT(rsp), .OSC_RDY_IN(osc_rdy), .EXT_OSC_CLK_IN(ext_clk),
        .SLOW_OSC_CLK_IN(slow_clk), .EXT_TICK_128K_IN(tick), .EXT_EVENT_IN(ext_event),
        .INT_REQ_IN(int_req), .MCLK_SEL_OUT(sel), .MCLK_DIV_OUT(div), .CPU_CLK_EN_OUT(cpu),
        .PERIPH_CLK_EN_OUT(periph), .MAIN_REG_ON_OUT(main_reg), .PLL_REF_EXT_OUT(pll_ext),
        .FAST_TRIM_OUT(trim), .WAKE_TBASE_EXT_OUT(tbase), .CLKOUT_SEL_OUT(co_sel),
        .CLKOUT_EN_OUT(co_en));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask

    task automatic wait_sel(input logic [2:0] exp, input int lim);
        n = 0;
        while (sel !== exp && n < lim) begin
            @(posedge clk);
            n++;
        end
        `CHK(sel, exp)
    endtask

    initial begin
        #300000;
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({sel, div, cpu, periph, main_reg, pll_ext, trim, tbase, co_sel, co_en},
            {3'h1, 2'h3, 1'h1, 8'hFF, 1'h1, 1'h0, 3'h4, 1'h0, 2'h0, 1'h0})
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            `CHK({err, rd}, {(i == 6), rst_val[i]})
        end
        // gating, trim and pin-routing fields, every clock-output code
        apb(1'b1, 12'h008, 32'h0000_00A5);
        apb(1'b1, 12'h010, 32'h0000_0003);
        `CHK({periph, trim}, {8'hA5, 3'h3})
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h00C, 32'h0000_0138 | (32'(i) << 6));
            `CHK({co_sel, co_en, pll_ext, tbase}, {2'(i), 3'h7})
        end
        // switch to external before it is ready
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (50) @(posedge clk);
        `CHK(sel, 3'h1)
        ext_on <= 1'b1;
        wait_sel(3'h0, 600);
        @(posedge clk);
        `CHK({sel, div}, {3'h4, 2'h0})
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rd[4:0], 5'h02)
        apb(1'b1, 12'h000, 32'h0000_0003);
        repeat (20) @(posedge clk);
        `CHK(sel, 3'h4)
        // external clock dies under the monitor
        ext_on <= 1'b0;
        wait_sel(3'h1, 1000);
        `CHK({n > 390, div}, {1'h1, 2'h3})
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rd[5], 1'b1)
        apb(1'b1, 12'h004, 32'h0000_0020);
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rd[5], 1'b0)
        // slow master, then wait mode
        apb(1'b1, 12'h000, 32'h0000_0005);
        wait_sel(3'h2, 600);
        `CHK(div, 2'h1)
        apb(1'b1, 12'h00C, 32'h0000_0001);
        repeat (20) @(posedge clk);
        `CHK({cpu, periph, main_reg}, {1'h0, 8'hA5, 1'h1})
        // frozen by clock enable: request must not wake yet
        ce <= 1'b0;
        int_req <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK({cpu, sel}, {1'h0, 3'h0})
        ce <= 1'b1;
        wait_sel(3'h1, 20);
        `CHK({cpu, div}, {1'h1, 2'h3})
        int_req <= 1'b0;
        wait_sel(3'h2, 1000);
        `CHK(n >= 200, 1'b1)
        // active-halt regulator off/on by wake timer, halt by event only
        apb(1'b1, 12'h014, 32'h0000_0002);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h00C, pw[i]);
            repeat (2) @(posedge clk);
            `CHK({cpu, periph, main_reg, sel}, {1'h0, 8'h00, (i == 1), 3'h0})
            if (i == 2) begin
                int_req <= 1'b1;
                repeat (3500) @(posedge clk);
                `CHK(cpu, 1'b0)
                ext_event <= 1'b1;
            end
            wait_sel(3'h1, 4000);
            ext_event <= 1'b0;
            int_req <= 1'b0;
            wait_sel(3'h2, 1000);
        end
        give_verdict();
    end
endmodule
